// ==== hw/tpg_cfg.svh ====
// constants of the test packet generator control block
`ifndef TPG_CFG_SVH
`define TPG_CFG_SVH
`define TPG_CTRL_RESET   16'h0000
`define TPG_DATA_RESET   16'h00AA
`define TPG_CTRL_WMASK   16'hFF7F
`define TPG_BIT_EN       0
`define TPG_BIT_START    1
`define TPG_BIT_BURST    12
`define TPG_BIT_MODE     13
`define TPG_CHUNK        16'd10000
`define TPG_HDR_BYTES    14'd14
`define TPG_FCS_BYTES    14'd4
`define TPG_VIEW_SYNC    4'h9
`define TPG_CRC_POLY     32'hEDB88320
`endif

// ==== hw/tpg_pkg.sv ====
// types of the test packet generator control block
package tpg_pkg;
    typedef enum logic [2:0] {
        TPG_IDLE  = 3'b000,
        TPG_HDR   = 3'b001,
        TPG_PAY   = 3'b010,
        TPG_FCS   = 3'b011,
        TPG_GAP   = 3'b100
    } tpg_state_t;
    typedef enum logic [1:0] {
        TPG_DBG_CHAN  = 2'b00,
        TPG_DBG_SYNC  = 2'b01,
        TPG_DBG_TRACE = 2'b10,
        TPG_DBG_SUB   = 2'b11
    } tpg_dbg_kind_t;
endpackage

// ==== hw/tpg_ctrl.sv ====
// test packet generator: control register, framing, payload, crc
`include "tpg_cfg.svh"
module tpg_ctrl
    import tpg_pkg::*;
#(
    parameter logic [47:0] ADDR_PREFIX = 48'h0A_BC_DE_FF_FF_F0  // arbitrary vendor prefix
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        ctrl_wr,
    input  wire logic [15:0] ctrl_wdata,
    input  wire logic        data_wr,
    input  wire logic [15:0] data_wdata,
    input  wire logic [7:0]  dbg_byte,
    output logic [15:0]      packet_gen_control,
    output logic [15:0]      payload_data_reg,
    output logic             tx_valid,
    output logic [7:0]       tx_byte,
    output logic             tx_sof,
    output logic             tx_eof,
    output logic [1:0]       dbg_channel,
    output logic [1:0]       dbg_phase,
    output tpg_dbg_kind_t    dbg_kind,
    output logic             gen_busy
);
    logic [15:0]   ctrl_q, ctrl_d, data_q, data_d;
    tpg_state_t    st_q, st_d;
    logic [13:0]   cnt_q, cnt_d, len_q, len_d;
    logic [15:0]   pkt_q, pkt_d;
    logic [1:0]    sub_q, sub_d;
    logic [31:0]   crc_q, crc_d, lfsr_q, lfsr_d;
    logic [7:0]    inc_q, inc_d, byte_d, byte_q;
    logic          val_d, val_q, sof_d, sof_q, eof_d, eof_q;
    logic [1:0]    ch_d, ch_q, ph_d, ph_q;
    tpg_dbg_kind_t kind_d, kind_q;
    logic [13:0]   size_len, gap_len, rnd_len, pay_len;
    logic [47:0]   da, sa;
    logic [7:0]    hdr_byte;
    logic          en, start, single, burst, last_pkt;
    logic          busy_d, busy_q;

    assign en     = ctrl_q[`TPG_BIT_EN];
    assign start  = ctrl_q[`TPG_BIT_START];
    assign single = ctrl_q[`TPG_BIT_MODE];
    assign burst  = ctrl_q[`TPG_BIT_BURST];
    assign da = {ADDR_PREFIX[47:4], data_q[15:12]};
    assign sa = {ADDR_PREFIX[47:4], data_q[11:8]};
    // length field carries payload bytes only
    assign pay_len = len_q - `TPG_HDR_BYTES - `TPG_FCS_BYTES;

    always_comb begin
        case (lfsr_q[1:0])
            2'b00:   rnd_len = 14'd64;
            2'b01:   rnd_len = 14'd256;
            2'b10:   rnd_len = 14'd1024;
            default: rnd_len = 14'd1518;
        endcase
    end
    always_comb begin
        case (ctrl_q[6:4])
            3'b000:  size_len = 14'd64;
            3'b001:  size_len = 14'd2048;
            3'b010:  size_len = 14'd256;
            3'b011:  size_len = 14'd4096;
            3'b100:  size_len = 14'd1024;
            3'b101:  size_len = 14'd1518;
            3'b110:  size_len = 14'd9000;
            default: size_len = rnd_len;
        endcase
    end
    // gap in byte times, 8 bits per byte cycle
    always_comb begin
        case (ctrl_q[11:10])
            2'b00:   gap_len = 14'd6;
            2'b01:   gap_len = 14'd12;
            2'b10:   gap_len = 14'd120;
            default: gap_len = 14'd1200;
        endcase
    end
    always_comb begin
        hdr_byte = 8'h00;
        if (cnt_q < 14'd6)
            hdr_byte = da[8'(6'd47 - 6'(cnt_q) * 6'd8) -: 8];
        else if (cnt_q < 14'd12)
            hdr_byte = sa[8'(6'd47 - 6'(cnt_q - 14'd6) * 6'd8) -: 8];
        else if (cnt_q == 14'd12)
            hdr_byte = {2'b00, pay_len[13:8]};
        else
            hdr_byte = pay_len[7:0];
    end

    // register file; reserved bit 7 stays zero whatever is written
    always_comb begin
        ctrl_d = ctrl_q;
        data_d = data_q;
        if (ctrl_wr)
            ctrl_d = ctrl_wdata & `TPG_CTRL_WMASK;
        if (data_wr)
            data_d = data_wdata;
        // single mode clears start when done
        if (!ctrl_wr && st_q == TPG_GAP && cnt_q == gap_len && single && last_pkt)
            ctrl_d[`TPG_BIT_START] = 1'b0;
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ctrl_q <= `TPG_CTRL_RESET;
            data_q <= `TPG_DATA_RESET;
        end else begin
            ctrl_q <= ctrl_d;
            data_q <= data_d;
        end
    end

    // single ends after one, or after four in burst
    assign last_pkt = burst ? (sub_q == 2'd3) : 1'b1;

    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] b);
        logic [31:0] r;
        r = c ^ {24'h000000, b};
        for (int i = 0; i < 8; i++)
            r = r[0] ? ((r >> 1) ^ `TPG_CRC_POLY) : (r >> 1);
        return r;
    endfunction

    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        len_d  = len_q;
        pkt_d  = pkt_q;
        sub_d  = sub_q;
        crc_d  = crc_q;
        inc_d  = inc_q;
        byte_d = 8'h00;
        val_d  = 1'b0;
        sof_d  = 1'b0;
        eof_d  = 1'b0;
        lfsr_d = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
        case (st_q)
            TPG_IDLE: begin
                sub_d = 2'd0;
                pkt_d = 16'd0;
                if (en && start) begin
                    st_d  = TPG_HDR;
                    cnt_d = 14'd0;
                    len_d = size_len;
                end
            end
            TPG_HDR: begin
                val_d  = 1'b1;
                byte_d = hdr_byte;
                sof_d  = (cnt_q == 14'd0);
                crc_d  = crc_step((cnt_q == 14'd0) ? 32'hFFFFFFFF : crc_q, hdr_byte);
                inc_d  = 8'h00;
                cnt_d  = cnt_q + 14'd1;
                if (cnt_q == `TPG_HDR_BYTES - 14'd1)
                    st_d = TPG_PAY;
            end
            TPG_PAY: begin
                val_d = 1'b1;
                case (ctrl_q[9:8])
                    2'b00:   byte_d = lfsr_q[7:0];
                    2'b01:   byte_d = inc_q;
                    2'b10:   byte_d = data_q[7:0];
                    default: byte_d = dbg_byte;
                endcase
                inc_d = inc_q + 8'h01;
                crc_d = crc_step(crc_q, byte_d);
                cnt_d = cnt_q + 14'd1;
                if (cnt_q == len_q - `TPG_FCS_BYTES - 14'd1)
                    st_d = TPG_FCS;
            end
            TPG_FCS: begin
                val_d  = 1'b1;
                byte_d = ~crc_q[7:0];
                crc_d  = {8'h00, crc_q[31:8]};
                cnt_d  = cnt_q + 14'd1;
                if (cnt_q == len_q - 14'd1) begin
                    eof_d = 1'b1;
                    st_d  = TPG_GAP;
                    cnt_d = 14'd1;
                end
            end
            TPG_GAP: begin
                cnt_d = cnt_q + 14'd1;
                if (!en || !start) begin
                    st_d = TPG_IDLE;
                end else if (cnt_q == gap_len) begin
                    sub_d = sub_q + 2'd1;
                    pkt_d = (pkt_q == `TPG_CHUNK - 16'd1) ? 16'd0 : pkt_q + 16'd1;
                    if (single && last_pkt) begin
                        st_d = TPG_IDLE;
                    end else begin
                        st_d  = TPG_HDR;
                        cnt_d = 14'd0;
                        len_d = size_len;
                    end
                end
            end
            default: st_d = TPG_IDLE;
        endcase
        // disable aborts at once, byte in flight dropped too
        if (!en) begin
            st_d   = TPG_IDLE;
            val_d  = 1'b0;
            sof_d  = 1'b0;
            eof_d  = 1'b0;
            byte_d = 8'h00;
        end
        // busy from a flop, same timing as the state
        busy_d = (st_d != TPG_IDLE);
    end

    // debug selection outputs
    always_comb begin
        ch_d   = ctrl_q[15:14];
        ph_d   = 2'd0;
        kind_d = TPG_DBG_SUB;
        if (burst && ctrl_q[3:2] == 2'd1) begin
            ch_d   = sub_q;
            kind_d = TPG_DBG_CHAN;
        end else if (burst && ctrl_q[3:2] == 2'd0) begin
            ph_d   = sub_q;
            kind_d = TPG_DBG_CHAN;
        end else if (!burst && data_q[3:0] == `TPG_VIEW_SYNC) begin
            if (ctrl_q[3:2] == 2'd0)
                kind_d = TPG_DBG_SYNC;
            else if (ctrl_q[3:2] == 2'd1)
                kind_d = TPG_DBG_TRACE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            st_q   <= TPG_IDLE;
            cnt_q  <= 14'd0;
            len_q  <= 14'd64;
            pkt_q  <= 16'd0;
            sub_q  <= 2'd0;
            crc_q  <= 32'hFFFFFFFF;
            lfsr_q <= 32'h0000_0001;
            inc_q  <= 8'h00;
            byte_q <= 8'h00;
            val_q  <= 1'b0;
            sof_q  <= 1'b0;
            eof_q  <= 1'b0;
            ch_q   <= 2'd0;
            ph_q   <= 2'd0;
            kind_q <= TPG_DBG_SUB;
            busy_q <= 1'b0;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            len_q  <= len_d;
            pkt_q  <= pkt_d;
            sub_q  <= sub_d;
            crc_q  <= crc_d;
            lfsr_q <= lfsr_d;
            inc_q  <= inc_d;
            byte_q <= byte_d;
            val_q  <= val_d;
            sof_q  <= sof_d;
            eof_q  <= eof_d;
            ch_q   <= ch_d;
            ph_q   <= ph_d;
            kind_q <= kind_d;
            busy_q <= busy_d;
        end
    end

    assign packet_gen_control = ctrl_q;
    assign payload_data_reg   = data_q;
    assign tx_valid           = val_q;
    assign tx_byte            = byte_q;
    assign tx_sof             = sof_q;
    assign tx_eof             = eof_q;
    assign dbg_channel        = ch_q;
    assign dbg_phase          = ph_q;
    assign dbg_kind           = kind_q;
    assign gen_busy           = busy_q;
endmodule

// ==== tb/tpg_ctrl_asserts.sv ====
// checker of the generator's register and stream ports
module tpg_ctrl_asserts (
    input wire logic        clk_sys,
    input wire logic        rst_b,
    input wire logic        ctrl_wr,
    input wire logic [15:0] ctrl_wdata,
    input wire logic        data_wr,
    input wire logic [15:0] data_wdata,
    input wire logic [15:0] packet_gen_control,
    input wire logic [15:0] payload_data_reg,
    input wire logic        tx_valid,
    input wire logic        tx_sof,
    input wire logic        tx_eof,
    input wire logic        gen_busy
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    sequence s_go;
        ctrl_wr && ctrl_wdata[1:0] == 2'b11 && !gen_busy;
    endsequence
    sequence s_quiet;
        !tx_valid [*6];
    endsequence
    ctrl_write_a: assert property (
        ctrl_wr |=> packet_gen_control == ($past(ctrl_wdata) & 16'hFF7F))
        else $error("control readback wrong");
    data_write_a: assert property (data_wr |=> payload_data_reg == $past(data_wdata))
        else $error("data readback wrong");
    start_lead_a: assert property (s_go |-> ##3 tx_sof)
        else $error("frame did not start");
    disabled_quiet_a: assert property ((!packet_gen_control[0]) [*2] |-> !tx_valid)
        else $error("output while disabled");
    eof_gap_a: assert property (tx_eof |=> s_quiet)
        else $error("gap too short");
    sof_valid_a: assert property (tx_sof |-> tx_valid && !tx_eof)
        else $error("bad start mark");
    eof_valid_a: assert property (tx_eof |-> tx_valid)
        else $error("bad end mark");
    valid_busy_a: assert property (tx_valid |-> gen_busy)
        else $error("byte while idle");
    // cycles since a non-burst single-mode frame ended with start still set
    logic [10:0] clr_wait_q;
    always_ff @(posedge clk_sys) begin
        if (!rst_b || !packet_gen_control[1] || ctrl_wr)
            clr_wait_q <= 11'd0;
        else if (tx_eof && packet_gen_control[13] && !packet_gen_control[12])
            clr_wait_q <= 11'd1;
        else if (clr_wait_q != 11'd0)
            clr_wait_q <= clr_wait_q + 11'd1;
    end
    // single mode clears start; bound covers the longest gap
    single_clear_a: assert property (clr_wait_q <= 11'd1210)
        else $error("start not cleared");
endmodule
bind tpg_ctrl tpg_ctrl_asserts u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata), .data_wr(data_wr), .data_wdata(data_wdata),
    .packet_gen_control(packet_gen_control), .payload_data_reg(payload_data_reg),
    .tx_valid(tx_valid), .tx_sof(tx_sof), .tx_eof(tx_eof), .gen_busy(gen_busy));

// ==== tb/tpg_rx_model.sv ====
// receiving end of the transmit stream: length, gap, header bytes, crc residue
module tpg_rx_model (
    input wire logic  clk_sys,
    input wire logic  tx_valid,
    input wire logic  [7:0] tx_byte,
    input wire logic  tx_sof,
    input wire logic  tx_eof,
    output int        frames,
    output int        flen,
    output int        gap,
    output logic      crc_ok,
    output logic [7:0] hdr [0:15]
);
    timeunit 1ns;
    timeprecision 1ns;
    int n;
    int k;
    int idle;
    logic [31:0] c;
    initial begin
        frames = 0;
        n = 0;
        idle = 0;
    end
    // residue check avoids locating the fcs bytes
    always @(posedge clk_sys) begin
        if (tx_valid) begin
            k = tx_sof ? 0 : n;
            if (tx_sof) gap = idle;
            if (k < 16) hdr[k] = tx_byte;
            c = (tx_sof ? 32'hFFFFFFFF : c) ^ {24'h000000, tx_byte};
            for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
            n = k + 1;
            idle = 0;
            if (tx_eof) begin
                flen = n;
                crc_ok = (c == 32'hDEBB20E3);
                frames++;
            end
        end else idle++;
    end
endmodule

// ==== tb/test_packet_generator_ctrl_tb.sv ====
// self-checking bench of the packet generator control block
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin err_total++; \
    $display("Error %s exp %0h got %0h", n, e, s); end end
module test_packet_generator_ctrl_tb
    import tpg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys, rst_b, ctrl_wr, data_wr, tx_valid, tx_sof, tx_eof, gen_busy, crc_ok;
    logic [15:0] ctrl_wdata, data_wdata, packet_gen_control, payload_data_reg;
    logic [7:0] dbg_byte, tx_byte;
    logic [7:0] hdr [0:15];
    logic [1:0] dbg_channel, dbg_phase;
    tpg_dbg_kind_t dbg_kind;
    int err_total, checks, frames, flen, gap;
    int sizes [7] = '{64, 2048, 256, 4096, 1024, 1518, 9000};
    int gaps [4] = '{6, 12, 120, 1200};
    tpg_ctrl u_dut (.clk_sys, .rst_b, .ctrl_wr, .ctrl_wdata, .data_wr, .data_wdata, .dbg_byte,
        .packet_gen_control, .payload_data_reg, .tx_valid, .tx_byte, .tx_sof, .tx_eof,
        .dbg_channel, .dbg_phase, .dbg_kind, .gen_busy);
    tpg_rx_model u_rx (.clk_sys, .tx_valid, .tx_byte, .tx_sof, .tx_eof, .frames, .flen, .gap,
        .crc_ok, .hdr);
    initial begin
        clk_sys = 0;
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic wr_c(input logic [15:0] v);
        ctrl_wr = 1;
        ctrl_wdata = v;
        @(negedge clk_sys) ctrl_wr = 0;
    endtask
    task automatic wait_fr(input int k);
        for (int i = 0; i < 40000 && frames < k; i++) @(negedge clk_sys);
        `CHK("frames", 1'b1, frames >= k)
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 20000 && gen_busy !== 1'b0; i++) @(negedge clk_sys);
        `CHK("idle", 1'b0, gen_busy)
        repeat (2) @(negedge clk_sys);
    endtask
    task automatic wait_sof();
        @(negedge clk_sys);
        for (int i = 0; i < 3000 && tx_sof !== 1'b1; i++) @(negedge clk_sys);
        `CHK("sof", 1'b1, tx_sof)
    endtask
    function automatic tpg_dbg_kind_t exp_kind(input logic [3:0] view, input logic mux_option);
        if (view != 4'h9) return TPG_DBG_SUB;
        return mux_option ? TPG_DBG_TRACE : TPG_DBG_SYNC;
    endfunction
    task automatic wrap_up();
        $display("counts checks=%0d errors=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // random debug bytes keep that input live
    always @(negedge clk_sys) dbg_byte <= 8'($urandom);
    initial begin
        // tests need about 30k cycles; allow 50k
        #400_000;
        err_total++;
        wrap_up();
    end
    initial begin
        logic [15:0] w;
        logic [2:0] s;
        logic [1:0] t;
        int f;
        void'($urandom(32'h74495c85));
        {rst_b, ctrl_wr, data_wr, ctrl_wdata, data_wdata} = '0;
        repeat (12) @(posedge clk_sys);
        @(negedge clk_sys) rst_b = 1;
        `CHK("ctrl reset", 16'h0000, packet_gen_control)
        `CHK("data reset", 16'h00AA, payload_data_reg)
        w = 16'($urandom) & 16'hFFFE | 16'h0002;
        wr_c(w);
        `CHK("ctrl rb", w & 16'hFF7F, packet_gen_control)
        repeat (8) @(negedge clk_sys);
        `CHK("no tx", 1'b0, tx_valid)
        wr_c(16'h0000);
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            s = i[2:0];
            t = i[0] ? 2'b01 : 2'b10;
            w = 16'($urandom);
            // odd passes force the sync/trace view code
            if (i[0]) w[3:0] = 4'h9;
            data_wr = 1;
            data_wdata = w;
            @(negedge clk_sys) data_wr = 0;
            `CHK("data rb", w, payload_data_reg)
            f = frames;
            wr_c({2'b00, 2'b10, 2'b00, t, 1'b0, s, 1'b0, i[2], 2'b11});
            wait_fr(f + 1);
            if (i < 7) `CHK("len", sizes[i], flen)
            else `CHK("rnd len", 1'b1, flen inside {64, 256, 1024, 1518})
            `CHK("crc", 1'b1, crc_ok)
            `CHK("kind", exp_kind(w[3:0], i[2]), dbg_kind)
            `CHK("len field", 16'(flen - 18), {hdr[12], hdr[13]})
            `CHK("da", w[15:12], hdr[5][3:0])
            `CHK("sa", w[11:8], hdr[11][3:0])
            if (t == 2'b10) `CHK("pay", w[7:0], hdr[15])
            else `CHK("inc", 8'(hdr[14] + 8'h01), hdr[15])
            wait_idle();
            `CHK("start clr", 1'b0, packet_gen_control[1])
            `CHK("one", f + 1, frames)
        end
        $display("test frames done");
        for (int g = 0; g < 4; g++) begin
            f = frames;
            wr_c({4'h0, 2'(g), 2'b01, 8'h03});
            wait_fr(f + 2);
            `CHK("gap", 1'b1, gap inside {[gaps[g] : gaps[g] + 2]})
            wr_c({4'h0, 2'(g), 2'b01, 8'h01});
            wait_idle();
            f = frames;
            repeat (1300) @(negedge clk_sys);
            `CHK("stopped", f, frames)
        end
        wr_c(16'h0103);
        wait_sof();
        repeat (20) @(negedge clk_sys);
        wr_c(16'h0000);
        @(negedge clk_sys);
        `CHK("abort", 1'b0, tx_valid)
        $display("test continuous done");
        for (int m = 0; m < 2; m++) begin
            t = 2'($urandom);
            f = frames;
            wr_c({t, 2'b11, 2'b00, 2'b11, 4'h0, 1'b0, 1'(m), 2'b11});
            for (int k = 0; k < 4; k++) begin
                wait_sof();
                `CHK("chan", m ? 2'(k) : t, dbg_channel)
                if (m == 0) `CHK("phase", 2'(k), dbg_phase)
                `CHK("kind", TPG_DBG_CHAN, dbg_kind)
            end
            wait_idle();
            `CHK("burst", f + 4, frames)
        end
        $display("test burst done");
        wrap_up();
    end
endmodule
